// ===== rtl/cbp_defs.svh
// Purpose: Constants for the processor bus address, data and parity path
// Assumes: Single 10 MHz reference clock
// Notes:   Definitions only
`ifndef CBP_DEFS_SVH
`define CBP_DEFS_SVH

`define CBP_DATA_W 32
`define CBP_LANES 4
`define CBP_ADDR_W 30
`define CBP_SNOOP_W 28
`define CBP_FIFO_DEPTH 8
`define CBP_BE_IDLE 4'hF
`define CBP_PARITY_STATUS_N_IDLE 1'b1
`define CBP_SNOOP_LSB 2

`endif

// ===== rtl/cbp_pkg.sv
// Purpose: Types for the processor bus address, data and parity path
// Assumes: Nothing
// Notes:   Types only
package cbp_pkg;
    // Bus cycle sequencer states
    typedef enum logic [1:0] {
        CBP_IDLE,
        CBP_FIRST,
        CBP_DATA
    } cbp_state_e;
endpackage : cbp_pkg

// ===== rtl/cbp_fifo.sv
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: One clock, asynchronous active-low reset
// Notes:   Depth must be a power of two
`timescale 1ns/10ps
module cbp_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];  // Storage array
    logic [AW-1:0] wr_ptr_reg;          // Write index
    logic [AW-1:0] rd_ptr_reg;          // Read index
    logic [AW:0] count_reg;             // Words held
    logic [AW:0] count_next;            // Words held after this edge
    logic push;
    logic pop;

    assign out_valid = (count_reg != '0);
    assign out_data = mem_reg[rd_ptr_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Storage write
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    // Next fill level from this cycle's push and pop
    always_comb begin
        count_next = count_reg;
        if (push && !pop) begin
            count_next = count_reg + 1'b1;
        end else if (pop && !push) begin
            count_next = count_reg - 1'b1;
        end
    end

    // Pointers, count and registered not-full flag
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            in_ready <= 1'b1;
        end else begin
            // Flop keeps the fill-side ready free of logic
            in_ready <= (count_next != DEPTH[AW:0]);
            count_reg <= count_next;
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end
endmodule : cbp_fifo

// ===== rtl/cbp_bus_path.sv
// Purpose: Address, byte enable, data and parity path of the external bus
// Assumes: All pins synchronous to ref_clk; far side keeps its own timing
// Notes:   Write data is queued in an 8-word FIFO ahead of the bus
//
// Overview of operation
// - Everything runs on ref_clk rising edge
// - Drive word address with byte enables
// - Accept upper address lines for snoop invalidation
// - Float address lines during bus/address hold
// - Assert enables low only for used lanes
// - Enable n maps to data byte n
// - Float byte enables during bus hold
// - 32-bit data bus, byte 0 least significant
// - Drive write data from second clock on
// - Even parity per byte, timed with data
// - Read parity only affects status output
// - Status in clock after ready
// - Status low on error, high otherwise
// - Check only lanes enabled and bus sized
// - Status high otherwise, never floated
// - Burst ready treated like ready
`timescale 1ns/10ps
`include "cbp_defs.svh"
module cbp_bus_path (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Core request side
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [`CBP_ADDR_W-1:0] req_addr,
    input wire logic [`CBP_LANES-1:0] req_lanes,
    input wire logic [`CBP_DATA_W-1:0] req_wdata,
    // Core read return
    output logic rd_valid,
    output logic [`CBP_DATA_W-1:0] rd_data,
    // Snoop invalidation to the core
    output logic snoop_valid,
    output logic [`CBP_SNOOP_W-1:0] snoop_addr,
    // Snoop strobe from the far side
    input wire logic snoop_strobe,
    // Hold controls
    input wire logic bus_hold,
    input wire logic address_hold_request,
    // Address pins
    input wire logic [`CBP_ADDR_W-1:0] word_address_lines_i,
    output logic [`CBP_ADDR_W-1:0] word_address_lines_o,
    output logic word_address_lines_oe,
    // Byte enables
    output logic [`CBP_LANES-1:0] byte_lane_enable_n,
    output logic byte_lane_enable_oe,
    // Data and parity pins
    input wire logic [`CBP_DATA_W-1:0] data_lines_i,
    output logic [`CBP_DATA_W-1:0] data_lines_o,
    output logic data_lines_oe,
    input wire logic [`CBP_LANES-1:0] lane_parity_bits_i,
    output logic [`CBP_LANES-1:0] lane_parity_bits_o,
    output logic lane_parity_bits_oe,
    // Ready and bus size
    input wire logic ready_n,
    input wire logic burst_ready_n,
    input wire logic bus_size_byte_n,
    input wire logic bus_size_half_n,
    // Parity status
    output logic parity_status_n
);
    localparam int RQW = 1 + `CBP_ADDR_W + `CBP_LANES + `CBP_DATA_W;

    //------------------------------------------------------------
    // Helper functions
    //------------------------------------------------------------
    // Even parity bit per lane: data plus bit has even ones
    function automatic logic [`CBP_LANES-1:0] lane_par(
        input logic [`CBP_DATA_W-1:0] d
    );
        logic [`CBP_LANES-1:0] p;
        p = '0;
        for (int i = 0; i < `CBP_LANES; i++) begin
            p[i] = ^d[8*i +: 8];
        end
        return p;
    endfunction : lane_par

    // Lanes checked, narrowed by the bus size inputs
    function automatic logic [`CBP_LANES-1:0] lane_mask(
        input logic [`CBP_LANES-1:0] be_n,
        input logic bs8_n,
        input logic bus_size_half_n_n
    );
        logic [`CBP_LANES-1:0] m;
        m = ~be_n;
        if (!bs8_n) begin
            m = m & (m ^ (m - 1'b1)) & (m - 1'b0); // Lowest lane only
        end else if (!bus_size_half_n_n) begin
            m = (m[1:0] != 2'b00) ? {2'b00, m[1:0]} : {m[3:2], 2'b00};
        end
        return m;
    endfunction : lane_mask

    //------------------------------------------------------------
    // Request FIFO
    //------------------------------------------------------------
    logic fifo_valid;
    logic fifo_pop;
    logic [RQW-1:0] fifo_data;

    cbp_fifo #(
        .WIDTH(RQW),
        .DEPTH(`CBP_FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .in_valid(req_valid),
        .in_ready(req_ready),
        .in_data({req_write, req_addr, req_lanes, req_wdata}),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    //------------------------------------------------------------
    // Cycle sequencer
    //------------------------------------------------------------
    cbp_pkg::cbp_state_e state_reg;
    logic wr_reg;                        // Current cycle is a write
    logic [`CBP_DATA_W-1:0] wdata_reg;   // Current write word
    logic any_ready;
    logic hold_any;

    // Burst ready counts exactly as ready
    assign any_ready = !ready_n || !burst_ready_n;
    assign hold_any = bus_hold || address_hold_request;
    assign fifo_pop = (state_reg == cbp_pkg::CBP_IDLE) && fifo_valid
                      && !bus_hold;

    // State: idle, first clock, data clocks until ready
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= cbp_pkg::CBP_IDLE;
        end else begin
            unique case (state_reg)
                cbp_pkg::CBP_IDLE: begin
                    if (fifo_pop) begin
                        state_reg <= cbp_pkg::CBP_FIRST;
                    end
                end
                // Ready is ignored in the first clock
                cbp_pkg::CBP_FIRST: begin
                    state_reg <= cbp_pkg::CBP_DATA;
                end
                cbp_pkg::CBP_DATA: begin
                    if (any_ready) begin
                        state_reg <= cbp_pkg::CBP_IDLE;
                    end
                end
            endcase
        end
    end

    // Latch the request taken from the FIFO
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_reg <= 1'b0;
            wdata_reg <= '0;
            word_address_lines_o <= '0;
            byte_lane_enable_n <= `CBP_BE_IDLE;
        end else if (fifo_pop) begin
            wr_reg <= fifo_data[RQW-1];
            word_address_lines_o <=
                fifo_data[`CBP_LANES+`CBP_DATA_W +: `CBP_ADDR_W];
            // Used lanes low, unused high
            byte_lane_enable_n <= ~fifo_data[`CBP_DATA_W +: `CBP_LANES];
            wdata_reg <= fifo_data[`CBP_DATA_W-1:0];
        end else if (state_reg == cbp_pkg::CBP_DATA && any_ready) begin
            byte_lane_enable_n <= `CBP_BE_IDLE;
        end
    end

    //------------------------------------------------------------
    // Pin drivers
    //------------------------------------------------------------
    // Address and byte enable output enables follow hold inputs
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            word_address_lines_oe <= 1'b0;
            byte_lane_enable_oe <= 1'b0;
        end else begin
            word_address_lines_oe <= !hold_any;
            byte_lane_enable_oe <= !bus_hold;
        end
    end

    // Write data and parity from second clock until ready
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            data_lines_o <= '0;
            data_lines_oe <= 1'b0;
            lane_parity_bits_o <= '0;
            lane_parity_bits_oe <= 1'b0;
        end else if (state_reg == cbp_pkg::CBP_FIRST && wr_reg) begin
            // Byte n of the word sits on lane n
            data_lines_o <= wdata_reg;
            lane_parity_bits_o <= lane_par(wdata_reg);
            data_lines_oe <= 1'b1;
            lane_parity_bits_oe <= 1'b1;
        end else if (state_reg != cbp_pkg::CBP_DATA || any_ready) begin
            data_lines_oe <= 1'b0;
            lane_parity_bits_oe <= 1'b0;
        end
    end

    //------------------------------------------------------------
    // Read return and parity check
    //------------------------------------------------------------
    logic rd_take;
    logic [`CBP_LANES-1:0] chk_mask;
    logic [`CBP_LANES-1:0] bad_lanes;

    assign rd_take = (state_reg == cbp_pkg::CBP_DATA) && any_ready
                     && !wr_reg;
    assign chk_mask = lane_mask(byte_lane_enable_n, bus_size_byte_n,
                                bus_size_half_n);
    // Far side returns even parity with the data
    assign bad_lanes = (lane_par(data_lines_i) ^ lane_parity_bits_i)
                       & chk_mask;

    // Read data passes unchanged whatever the parity
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_valid <= 1'b0;
            rd_data <= '0;
        end else begin
            rd_valid <= rd_take;
            if (rd_take) begin
                rd_data <= data_lines_i;
            end
        end
    end

    // Status one clock after ready, high at all other times
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            parity_status_n <= `CBP_PARITY_STATUS_N_IDLE;
        end else if (rd_take) begin
            parity_status_n <= ~(|bad_lanes);
        end else begin
            parity_status_n <= `CBP_PARITY_STATUS_N_IDLE;
        end
    end

    //------------------------------------------------------------
    // Snoop address capture
    //------------------------------------------------------------
    // Upper lines are inputs while the far side holds the address
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            snoop_valid <= 1'b0;
            snoop_addr <= '0;
        end else begin
            snoop_valid <= snoop_strobe && address_hold_request;
            if (snoop_strobe && address_hold_request) begin
                snoop_addr <= word_address_lines_i[`CBP_ADDR_W-1:
                                                   `CBP_SNOOP_LSB];
            end
        end
    end

    //------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------
    parity_status_n_timing_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        rd_take |=> parity_status_n == ~(|$past(bad_lanes)))
        else $error("parity status wrong after read ready");
    parity_status_n_idle_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        !$past(rd_take) |-> parity_status_n)
        else $error("parity status low outside check clock");
    addr_float_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        hold_any |=> !word_address_lines_oe)
        else $error("address driven during hold");
    be_float_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        bus_hold |=> !byte_lane_enable_oe)
        else $error("byte enables driven during bus hold");
    wr_drive_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (state_reg == cbp_pkg::CBP_FIRST && wr_reg) |=>
        data_lines_oe && lane_parity_bits_oe)
        else $error("write data not driven in second clock");
    par_even_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        data_lines_oe |-> lane_parity_bits_o == lane_par(data_lines_o))
        else $error("write parity not even");
    rd_float_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (state_reg == cbp_pkg::CBP_DATA && !wr_reg) |-> !data_lines_oe)
        else $error("data driven during read");
    rd_pass_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        rd_take |=> rd_valid && rd_data == $past(data_lines_i))
        else $error("read data altered");
endmodule : cbp_bus_path

// ===== testbench/cbp_far_model.sv
// Purpose: Far-side bus logic answering the block's bus cycles
// Assumes: A cycle runs while the byte enables are active
// Notes:   Wait clocks, ready kind and parity faults set by the bench
`timescale 1ns/10ps
`include "cbp_defs.svh"
module cbp_far_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Pins watched
    input wire logic [`CBP_LANES-1:0] byte_lane_enable_n,
    input wire logic byte_lane_enable_oe,
    // Settings from the bench
    input wire logic [7:0] wait_clks,
    input wire logic use_burst,
    input wire logic [`CBP_DATA_W-1:0] rd_word,
    input wire logic [`CBP_LANES-1:0] bad_par,
    // Answer to the block
    output logic ready_n,
    output logic burst_ready_n,
    output logic [`CBP_DATA_W-1:0] far_data,
    output logic [`CBP_LANES-1:0] far_par
);
    logic [7:0] cnt_reg; // Clocks since enables went active
    logic rdy_reg; // Ready strobe for this clock
    logic go; // Answer due at this edge
    logic [3:0] good; // Even parity of the read word
    assign go = byte_lane_enable_oe && cnt_reg == wait_clks &&
                byte_lane_enable_n != `CBP_BE_IDLE;
    always_comb begin
        for (int l = 0; l < 4; l++) good[l] = ^rd_word[8*l +: 8];
    end
    // Count the clocks of a cycle, answer after the chosen wait
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_reg <= '0;
            rdy_reg <= 1'b0;
        end else if (byte_lane_enable_n != `CBP_BE_IDLE) begin
            cnt_reg <= cnt_reg + 8'h01;
            rdy_reg <= go;
        end else begin
            cnt_reg <= '0;
            rdy_reg <= 1'b0;
        end
    end
    // Data only valid with ready; released lines toggle, parity pulls up
    always_ff @(posedge ref_clk) begin
        far_data <= go ? rd_word : ~far_data;
        far_par <= go ? good ^ bad_par : 4'hF;
    end
    assign ready_n = !(rdy_reg && !use_burst);
    assign burst_ready_n = !(rdy_reg && use_burst);
endmodule : cbp_far_model

// ===== testbench/cpu_bus_data_parity_path_test.sv
// Purpose: Self-checking bench for the bus address, data, parity path
// Assumes: Far side modelled by cbp_far_model
// Notes:   Seeded random stimulus with hold, fill and fault corners
`timescale 1ns/10ps
module cpu_bus_data_parity_path_test;
    logic ref_clk, reset_n, req_valid, req_ready, req_write, rd_valid;
    logic snoop_valid, snoop_strobe, bus_hold, address_hold_request;
    logic wal_oe, be_oe, d_oe, p_oe, ready_n, burst_ready_n, use_burst;
    logic bs8_n, bus_size_half_n_n, parity_status_n_n;
    logic [29:0] req_addr, wal_i, wal_o, snoop_drv;
    logic [27:0] snoop_addr;
    logic [31:0] req_wdata, rd_data, d_i, d_o, rd_word, far_data;
    logic [3:0] req_lanes, be_n, p_i, p_o, bad_par, far_par;
    logic [7:0] wait_clks;
    logic [29:0] a_q[8];
    logic [31:0] d_q[8];
    logic [3:0] l_q[8];
    int n_mismatch = 0;
    int checks_done = 0;
    // Shared pins resolved from the block's output enables; far side drives otherwise
    assign wal_i = wal_oe ? wal_o : snoop_drv;
    assign d_i = d_oe ? d_o : far_data;
    assign p_i = p_oe ? p_o : far_par;
    cbp_bus_path cbp_bus_path_inst (.ref_clk(ref_clk), .reset_n(reset_n),
        .req_valid(req_valid), .req_ready(req_ready),
        .req_write(req_write), .req_addr(req_addr), .req_lanes(req_lanes),
        .req_wdata(req_wdata), .rd_valid(rd_valid), .rd_data(rd_data),
        .snoop_valid(snoop_valid), .snoop_addr(snoop_addr),
        .snoop_strobe(snoop_strobe), .bus_hold(bus_hold),
        .address_hold_request(address_hold_request),
        .word_address_lines_i(wal_i), .word_address_lines_o(wal_o),
        .word_address_lines_oe(wal_oe), .byte_lane_enable_n(be_n),
        .byte_lane_enable_oe(be_oe), .data_lines_i(d_i),
        .data_lines_o(d_o), .data_lines_oe(d_oe),
        .lane_parity_bits_i(p_i), .lane_parity_bits_o(p_o),
        .lane_parity_bits_oe(p_oe), .ready_n(ready_n),
        .burst_ready_n(burst_ready_n), .bus_size_byte_n(bs8_n),
        .bus_size_half_n(bus_size_half_n_n), .parity_status_n(parity_status_n_n));
    cbp_far_model cbp_far_model_inst (.ref_clk(ref_clk), .reset_n(reset_n),
        .byte_lane_enable_n(be_n), .byte_lane_enable_oe(be_oe),
        .wait_clks(wait_clks), .use_burst(use_burst), .rd_word(rd_word),
        .bad_par(bad_par), .ready_n(ready_n),
        .burst_ready_n(burst_ready_n), .far_data(far_data),
        .far_par(far_par));
    // Compare one value and count it
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Print counts and verdict, then stop
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : finish_test
    // Offer one request and hold it until taken
    task automatic push(input logic wr, input logic [29:0] a,
                        input logic [3:0] ln, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        req_valid <= 1'b1;
        req_write <= wr;
        req_addr <= a;
        req_lanes <= ln;
        req_wdata <= d;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (req_ready !== 1'b1 && n < 50);
        if (n >= 50) check("req_ready", 0, 1);
        req_valid <= 1'b0;
    endtask : push
    // Wait for the edge at which a ready is sampled
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (ready_n !== 1'b0 && burst_ready_n !== 1'b0 && n < 200);
        if (n >= 200) check("ready wait", 0, 1);
    endtask : wait_rdy
    // Even parity bit per lane
    function automatic logic [3:0] par(input logic [31:0] d);
        for (int l = 0; l < 4; l++) par[l] = ^d[8*l +: 8];
    endfunction : par
    // Expected status: checked lanes from enables and bus size
    function automatic logic exp_parity_status_n(input logic [3:0] ln, input logic b8,
        input logic b16, input logic [3:0] bad);
        logic [3:0] chk;
        chk = ln;
        if (!b8) chk = ln & (~ln + 4'h1);
        else if (!b16) chk = ln[1:0] != 2'b00 ? {2'b00, ln[1:0]} : ln & 4'hC;
        return !(|(chk & bad));
    endfunction : exp_parity_status_n
    // Clock of 100 ns period
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    // Watchdog over the expected run length
    initial begin
        #2_000_000;
        n_mismatch++;
        finish_test();
    end
    // Main sequence
    initial begin
        {reset_n, req_valid, req_write, snoop_strobe, use_burst} = '0;
        {bus_hold, address_hold_request, bad_par, wait_clks} = '0;
        {req_addr, req_lanes, req_wdata, rd_word, snoop_drv} = '0;
        {bs8_n, bus_size_half_n_n} = 2'b11;
        void'($urandom(50));
        repeat (16) @(posedge ref_clk);
        #1;
        check("reset oe", {d_oe, p_oe, wal_oe, be_oe}, 0);
        check("reset parity_status_n", {be_n, parity_status_n_n}, 5'h1F);
        reset_n <= 1'b1;
        $display("reset test done");
        // Fill the buffer under bus hold, then drain with stalls
        bus_hold <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            a_q[i] = 30'($urandom);
            d_q[i] = i == 0 ? 32'hFFFF_FFFF : $urandom;
            l_q[i] = i == 1 ? 4'h8 : 4'($urandom_range(15, 1));
            push(1'b1, a_q[i], l_q[i], d_q[i]);
        end
        @(posedge ref_clk);
        #1;
        check("full ready", req_ready, 0);
        check("hold oe", {wal_oe, be_oe, d_oe}, 0);
        @(posedge ref_clk);
        bus_hold <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            wait_clks <= 8'(i % 4 * 3);
            use_burst <= i[0];
            wait_rdy();
            check("wr data", d_o, d_q[i]);
            check("wr par", {d_oe, p_oe, p_o}, {2'b11, par(d_q[i])});
            check("wr be", {be_oe, be_n}, {1'b1, ~l_q[i]});
            check("wr addr", {wal_oe, wal_o}, {1'b1, a_q[i]});
            @(posedge ref_clk);
            #1;
            check("wr after", {d_oe, p_oe, parity_status_n_n}, 3'b001);
        end
        $display("write test done");
        // Reads with random parity faults and bus sizes
        for (int i = 0; i < 16; i++) begin
            @(posedge ref_clk);
            l_q[0] = i == 0 ? 4'hF : 4'($urandom_range(15, 1));
            d_q[0] = $urandom;
            bs8_n <= i < 4 ? i[0] : 1'($urandom);
            bus_size_half_n_n <= i < 4 ? i[1] : 1'($urandom);
            bad_par <= i < 2 ? 4'h0 : 4'($urandom);
            rd_word <= d_q[0];
            wait_clks <= 8'(i % 3);
            use_burst <= i[1];
            push(1'b0, 30'($urandom), l_q[0], 32'($urandom));
            wait_rdy();
            check("rd be", be_n, 4'(~l_q[0]));
            #1;
            check("rd valid", rd_valid, 1'b1);
            check("rd data", rd_data, d_q[0]);
            check("rd parity_status_n", parity_status_n_n,
                  exp_parity_status_n(l_q[0], bs8_n, bus_size_half_n_n, bad_par));
            @(posedge ref_clk);
            #1;
            check("parity_status_n idle", {rd_valid, parity_status_n_n}, 2'b01);
        end
        $display("read test done");
        // Snoop address taken while address hold is granted
        @(posedge ref_clk);
        address_hold_request <= 1'b1;
        snoop_drv <= 30'($urandom);
        repeat (3) @(posedge ref_clk);
        #1;
        check("address_hold_request oe", wal_oe, 0);
        @(posedge ref_clk);
        snoop_strobe <= 1'b1;
        for (int n = 0; n < 20 && snoop_valid !== 1'b1; n++) begin
            @(posedge ref_clk);
            #1;
        end
        check("snoop addr", {snoop_valid, snoop_addr},
              {1'b1, snoop_drv[29:2]});
        @(posedge ref_clk);
        snoop_strobe <= 1'b0;
        address_hold_request <= 1'b0;
        $display("snoop test done");
        finish_test();
    end
endmodule : cpu_bus_data_parity_path_test
